// [verilog/usart_ctrl_pkg.sv]
/*
 Register map, field positions, reset values and encodings of the serial channel
 control block. Assumes a 32-bit AXI4-Lite bus with byte addresses.
*/
`default_nettype none
package usart_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int BAUD_W = 12;
   localparam logic [ADDR_W-1:0] OFF_CTRL_B = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL_C = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BAUD_LOW = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_BAUD_HIGH = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_CTRL_A = 8'h10;
   localparam int B_RXC_IE = 7;
   localparam int B_TXC_IE = 6;
   localparam int B_UDR_IE = 5;
   localparam int B_RX_EN = 4;
   localparam int B_TX_EN = 3;
   localparam int B_SIZE_HI = 2;
   localparam int B_RX9 = 1;
   localparam int B_TX9 = 0;
   localparam int C_MODE_LSB = 6;
   localparam int C_PAR_LSB = 4;
   localparam int C_STOP = 3;
   localparam int C_SIZE_LSB = 1;
   localparam int C_POL = 0;
   localparam int A_RXC = 7;
   localparam int A_TXC = 6;
   localparam int A_UDRE = 5;
   localparam int A_FE = 4;
   localparam int A_DOR = 3;
   localparam int A_PE = 2;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   localparam logic [7:0] CTRL_C_RESET = 8'h06;
   localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
   localparam logic [1:0] RX_DEPTH = 2'h2;
   localparam logic [2:0] SIZE_NINE = 3'h7;
   localparam logic [3:0] BITS_BASE = 4'h5;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] BITS_DEFAULT = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_RESERVED, MODE_MSPI} op_mode_t;
   typedef enum logic [1:0] {PAR_OFF, PAR_RESERVED, PAR_EVEN, PAR_ODD} parity_mode_t;
   typedef enum logic [2:0] {SEL_B, SEL_C, SEL_BL, SEL_BH, SEL_A, SEL_NONE} reg_sel_t;
endpackage
`default_nettype wire

// [verilog/usart_ctrl.sv]
/*
 Control, status and baud configuration of one serial channel, an AXI4-Lite slave.
 Assumes frame engines outside that shift bits and report events as one-cycle pulses,
 and a processor that supplies its global interrupt enable as a level.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] Receive-done request needs its enable bit 7, global enable and rx_done flag.
// [R2] Transmit-done request needs its enable bit 6, global enable and tx_done flag.
// [R3] Buffer-empty request needs its enable bit 5, global enable and empty flag.
// [R4] Receiver enable owns the input pin; clearing it flushes buffer and error flags.
// [R5] Transmitter enable makes the transmitter own the output pin.
// [R6] After disable, keep the output pin until shifter and buffer are both empty.
// [R7] Software reads the received ninth bit before the low data bits.
// [R8] Software writes the ninth bit to send before the low data bits.
// [R9] Mode field: 0 async, 1 sync, 2 reserved, 3 master SPI.
// [R10] Parity field: 0 off, 1 reserved, 2 even, 3 odd; transmitter appends parity.
// [R11] Receiver checks parity of each frame and flags a mismatch.
// [R12] Stop select gives one or two transmit stop bits; receiver ignores it.
// [R13] Size code 0..3 gives 5..8 bits, 7 gives 9, both directions.
// [R14] Polarity 0: transmit on rising, sample on falling edge; 1 swaps.
// [R15] Software keeps polarity zero in asynchronous mode.
// [R16] Baud value is 12 bits: high byte holds top four, low byte eight.
// [R17] Writing the low baud byte reloads the prescaler at once.
// [R18] Software writes zeros to the reserved upper baud bits.
// [R19] Baud change applies at once, frames in flight may break.
// [R20] Receive-done flag follows unread data in buffer, cleared on disable.
// [R21] Transmit-done sets when frame out and buffer empty; cleared by ack or one.
// [R22] Buffer-empty flag shows transmit buffer free, set after reset.
// [R23] Software avoids reserved mode, parity and size codes.
module usart_ctrl
   import usart_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic globalIrqEnable,
   input wire logic txDoneIrqTaken,
   input wire logic rxFrameValid,
   input wire logic [8:0] rxFrameData,
   input wire logic rxFrameParity,
   input wire logic rxFrameStop,
   input wire logic rxOverrun,
   input wire logic rxBufferRead,
   input wire logic txBufferWrite,
   input wire logic [8:0] txFrameData,
   input wire logic txShiftLoad,
   input wire logic txShiftDone,
   input wire logic txShiftBusy,
   output logic rxIrqReq,
   output logic txIrqReq,
   output logic emptyIrqReq,
   output logic rxPinOwned,
   output logic txPinOwned,
   output logic rxFlush,
   output logic [1:0] operatingMode,
   output logic [1:0] parityMode,
   output logic twoStopBits,
   output logic [3:0] dataBits,
   output logic txParityBit,
   output logic txChangeOnRising,
   output logic rxSampleOnRising,
   output logic transmitNinthBit,
   output logic [BAUD_W-1:0] baudDivisor,
   output logic baudTick
);
   logic awHeld_reg, wHeld_reg, wLane0_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [7:0] wData_reg;
   logic [7:0] ctrlB_reg, ctrlC_reg, readByte;
   logic [3:0] baudHigh_reg;
   logic [7:0] baudLow_reg;
   logic [BAUD_W-1:0] baudCnt_reg;
   logic [1:0] rxCount_reg;
   logic frameErr_reg, overrun_reg, parityErr_reg, txDone_reg, txBufFull_reg;
   logic rxEnPrev_reg;
   logic doWrite, regWrite, rxStore, rxTake, rxMismatch;
   reg_sel_t selW, selR;

   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
      if (a == OFF_CTRL_B) decode = SEL_B;
      else if (a == OFF_CTRL_C) decode = SEL_C;
      else if (a == OFF_BAUD_LOW) decode = SEL_BL;
      else if (a == OFF_BAUD_HIGH) decode = SEL_BH;
      else if (a == OFF_CTRL_A) decode = SEL_A;
      else decode = SEL_NONE;
   endfunction

   function automatic logic [3:0] bits_of(input logic [2:0] code);
      if (!code[2]) bits_of = BITS_BASE + {2'h0, code[1:0]};
      else if (code == SIZE_NINE) bits_of = BITS_NINE;
      else bits_of = BITS_DEFAULT;
   endfunction

   // Odd parity is even parity inverted
   function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) p = p ^ d[i];
      end
      parity_of = p;
   endfunction

   assign selW = decode(awAddr_reg);
   assign selR = decode(s_axi_araddr);
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign regWrite = doWrite && wLane0_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         awHeld_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         awAddr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_reg <= 1'b1;
         awAddr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         awHeld_reg <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!awHeld_reg) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wHeld_reg <= 1'b0;
         s_axi_wready <= 1'b0;
         wData_reg <= 8'h00;
         wLane0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_reg <= 1'b1;
         wData_reg <= s_axi_wdata[7:0];
         wLane0_reg <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         wHeld_reg <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!wHeld_reg) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (selW == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Upper baud bits always read back as zero
   always_comb begin
      readByte = 8'h00;
      if (selR == SEL_B) readByte = ctrlB_reg;
      else if (selR == SEL_C) readByte = ctrlC_reg;
      else if (selR == SEL_BL) readByte = baudLow_reg;
      else if (selR == SEL_BH) readByte = {4'h0, baudHigh_reg};
      else if (selR == SEL_A) begin
         readByte[A_RXC] = rxCount_reg != 2'h0;
         readByte[A_TXC] = txDone_reg;
         readByte[A_UDRE] = !txBufFull_reg;
         readByte[A_FE] = frameErr_reg;
         readByte[A_DOR] = overrun_reg;
         readByte[A_PE] = parityErr_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, readByte};
         s_axi_rresp <= (selR == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Received ninth bit is hardware owned; software writes to it are dropped
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrlB_reg <= CTRL_B_RESET;
         ctrlC_reg <= CTRL_C_RESET;
      end else begin
         if (regWrite && selW == SEL_B) begin
            ctrlB_reg[7:2] <= wData_reg[7:2];
            ctrlB_reg[B_TX9] <= wData_reg[B_TX9];
         end
         if (rxStore) ctrlB_reg[B_RX9] <= rxFrameData[8];
         if (regWrite && selW == SEL_C) ctrlC_reg <= wData_reg;
      end
   end

   // No wait for frame edges on a reload: a shifting frame may be lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         baudHigh_reg <= BAUD_RESET[11:8];
         baudLow_reg <= BAUD_RESET[7:0];
         baudCnt_reg <= BAUD_RESET;
         baudTick <= 1'b0;
      end else begin
         if (regWrite && selW == SEL_BH) baudHigh_reg <= wData_reg[3:0]; // see [R16]
         if (regWrite && selW == SEL_BL) begin
            baudLow_reg <= wData_reg;
            baudCnt_reg <= {baudHigh_reg, wData_reg}; // see [R17] see [R19]
            baudTick <= 1'b0;
         end else if (baudCnt_reg == '0) begin
            baudCnt_reg <= {baudHigh_reg, baudLow_reg};
            baudTick <= 1'b1;
         end else begin
            baudCnt_reg <= baudCnt_reg - 1'b1;
            baudTick <= 1'b0;
         end
      end
   end

   assign rxStore = ctrlB_reg[B_RX_EN] && rxFrameValid && rxCount_reg < RX_DEPTH;
   assign rxTake = rxBufferRead && rxCount_reg != 2'h0;
   assign rxMismatch = ctrlC_reg[C_PAR_LSB+1] && (rxFrameParity != parity_of(rxFrameData,
                       dataBits, ctrlC_reg[C_PAR_LSB])); // see [R11]

   // Frame and parity error flags collect every frame stored since the last read, overrun every rxOverrun pulse; a new event beats a same-cycle read
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !ctrlB_reg[B_RX_EN]) begin // see [R4] see [R20]
         rxCount_reg <= 2'h0;
         frameErr_reg <= 1'b0;
         overrun_reg <= 1'b0;
         parityErr_reg <= 1'b0;
      end else begin
         rxCount_reg <= rxCount_reg + {1'b0, rxStore} - {1'b0, rxTake};
         frameErr_reg <= (frameErr_reg && !rxTake) || (rxStore && !rxFrameStop);
         overrun_reg <= (overrun_reg && !rxTake) || rxOverrun;
         parityErr_reg <= (parityErr_reg && !rxTake) || (rxStore && rxMismatch);
      end
   end

   // Writes into a full buffer are ignored; empty after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         txBufFull_reg <= 1'b0; // see [R22]
         txDone_reg <= 1'b0;
      end else begin
         if (txBufferWrite && !txBufFull_reg && ctrlB_reg[B_TX_EN]) txBufFull_reg <= 1'b1;
         else if (txShiftLoad) txBufFull_reg <= 1'b0;
         if (txShiftDone && !txBufFull_reg) txDone_reg <= 1'b1; // see [R21]
         else if (txDoneIrqTaken || (regWrite && selW == SEL_A && wData_reg[A_TXC]))
            txDone_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rxPinOwned <= 1'b0;
         txPinOwned <= 1'b0;
         rxEnPrev_reg <= 1'b0;
         rxFlush <= 1'b0;
      end else begin
         rxPinOwned <= ctrlB_reg[B_RX_EN]; // see [R4]
         rxEnPrev_reg <= ctrlB_reg[B_RX_EN];
         rxFlush <= rxEnPrev_reg && !ctrlB_reg[B_RX_EN];
         if (ctrlB_reg[B_TX_EN]) txPinOwned <= 1'b1; // see [R5]
         else if (!txBufFull_reg && !txShiftBusy) txPinOwned <= 1'b0; // see [R6]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rxIrqReq <= 1'b0;
         txIrqReq <= 1'b0;
         emptyIrqReq <= 1'b0;
      end else begin
         rxIrqReq <= ctrlB_reg[B_RXC_IE] && globalIrqEnable && rxCount_reg != 2'h0; // see [R1]
         txIrqReq <= ctrlB_reg[B_TXC_IE] && globalIrqEnable && txDone_reg; // see [R2]
         emptyIrqReq <= ctrlB_reg[B_UDR_IE] && globalIrqEnable && !txBufFull_reg; // see [R3]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dataBits <= BITS_DEFAULT;
         txParityBit <= 1'b0;
         txChangeOnRising <= 1'b1;
         rxSampleOnRising <= 1'b0;
      end else begin
         dataBits <= bits_of({ctrlB_reg[B_SIZE_HI], ctrlC_reg[C_SIZE_LSB+:2]}); // see [R13]
         txParityBit <= parity_of(txFrameData, dataBits, ctrlC_reg[C_PAR_LSB]); // see [R10]
         txChangeOnRising <= !ctrlC_reg[C_POL]; // see [R14]
         rxSampleOnRising <= ctrlC_reg[C_POL];
      end
   end

   assign operatingMode = ctrlC_reg[C_MODE_LSB+1:C_MODE_LSB]; // see [R9]
   assign parityMode = ctrlC_reg[C_PAR_LSB+1:C_PAR_LSB]; // see [R10]
   assign twoStopBits = ctrlC_reg[C_STOP]; // see [R12]
   assign transmitNinthBit = ctrlB_reg[B_TX9];
   assign baudDivisor = {baudHigh_reg, baudLow_reg}; // see [R16]

   rx_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R1]
      ##1 rxIrqReq == $past(ctrlB_reg[B_RXC_IE] && globalIrqEnable && rxCount_reg != 2'h0))
      else $error("receive request mismatch");
   tx_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R2]
      txIrqReq |-> $past(txDone_reg) && $past(globalIrqEnable) && $past(ctrlB_reg[B_TXC_IE]))
      else $error("transmit request without cause");
   empty_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R3]
      ctrlB_reg[B_UDR_IE] && globalIrqEnable && !txBufFull_reg |=> emptyIrqReq)
      else $error("empty request missing");
   rx_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R4]
      !ctrlB_reg[B_RX_EN] |=> rxCount_reg == 2'h0 && !parityErr_reg && !frameErr_reg)
      else $error("receive buffer not flushed");
   tx_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
      $fell(txPinOwned) |-> !$past(txBufFull_reg) && !$past(txShiftBusy))
      else $error("pin released with data pending");
   tx_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R5]
      $rose(ctrlB_reg[B_TX_EN]) |=> txPinOwned [*2])
      else $error("pin not taken");
   baud_reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R17]
      regWrite && selW == SEL_BL |=> baudCnt_reg == {baudHigh_reg, baudLow_reg} && !baudTick)
      else $error("prescaler not reloaded");
   baud_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R19]
      baudTick |-> baudCnt_reg == {$past(baudHigh_reg), $past(baudLow_reg)})
      else $error("tick without reload");
   parity_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R11]
      rxStore && rxMismatch |=> parityErr_reg)
      else $error("parity error lost");
   tx_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R21]
      txShiftDone && !txBufFull_reg |=> txDone_reg)
      else $error("transmit done lost");
   size_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R13]
      ##1 ($past(ctrlB_reg[B_SIZE_HI]) && $past(ctrlC_reg[2:1]) == 2'h3) |-> dataBits == 4'h9)
      else $error("nine bit size wrong");

   fill_c: cover property (@(posedge sys_clk) disable iff (!rst_n) rxCount_reg == RX_DEPTH);
   drain_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
      !ctrlB_reg[B_TX_EN] && txPinOwned ##1 !txPinOwned);
   perr_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(parityErr_reg));
   reload_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
      regWrite && selW == SEL_BL ##[1:300] baudTick);
endmodule
`default_nettype wire

// [tb/tx_engine_model.sv]
/*
 Transmit frame engine model that sits beside the control block.
 Assumes the bench pulses sendReq once for each data register write.
*/
`timescale 1ns/1ps
`default_nettype none
module tx_engine_model #(
   parameter int SHIFT_CYCLES = 12
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sendReq,
   output logic txBufferWrite,
   output logic txShiftLoad,
   output logic txShiftDone,
   output logic txShiftBusy
);
   logic pending;
   int count;
   always_ff @(posedge sys_clk) begin
      txBufferWrite <= rst_n && sendReq;
      txShiftLoad <= 1'b0;
      txShiftDone <= 1'b0;
      if (!rst_n) begin
         pending <= 1'b0;
         txShiftBusy <= 1'b0;
         count <= 0;
      end else if (pending && !txShiftBusy) begin
         // Shifter only takes the buffer once idle
         pending <= 1'b0;
         txShiftLoad <= 1'b1;
         txShiftBusy <= 1'b1;
         count <= SHIFT_CYCLES;
      end else if (txShiftBusy) begin
         count <= count - 1;
         txShiftBusy <= count > 1;
         txShiftDone <= count == 1;
      end else if (txBufferWrite) begin
         pending <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb/usart_control_and_baud_config_tb.sv]
/*
 Self-checking bench of the serial channel control block.
 Assumes the AXI4-Lite slave and the transmit engine model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module usart_control_and_baud_config_tb;
   import usart_ctrl_pkg::*;
   logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, dataBits;
   logic [1:0] s_axi_bresp, s_axi_rresp, operatingMode, parityMode, resp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic globalIrqEnable, txDoneIrqTaken, rxFrameValid, rxFrameParity, rxFrameStop, rxOverrun;
   logic rxBufferRead, txBufferWrite, txShiftLoad, txShiftDone, txShiftBusy, sendReq;
   logic [8:0] rxFrameData, txFrameData;
   logic rxIrqReq, txIrqReq, emptyIrqReq, rxPinOwned, txPinOwned, rxFlush, twoStopBits;
   logic txParityBit, txChangeOnRising, rxSampleOnRising, transmitNinthBit, baudTick;
   logic [BAUD_W-1:0] baudDivisor;
   logic [7:0] v;
   logic [1:0] mo, pa;
   logic [7:0] pc[4] = '{8'h26, 8'h36, 8'h20, 8'h30};
   logic [8:0] pd[4] = '{9'h007, 9'h007, 9'h0E1, 9'h0E1};
   logic pe[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   int n_mismatch = 0, checks = 0, flushes = 0, c, f0;
   usart_ctrl usart_ctrl_i (.*);
   tx_engine_model tx_engine_model_i (.*);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (rxFlush) flushes++;
   task automatic finish_test();
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic lim(input int n);
      if (n >= 600) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 600);
      resp = s_axi_bresp;
      lim(n);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 600);
      `CHK(s_axi_rdata, {24'h0, e})
      `CHK(s_axi_rresp, r)
      lim(n);
   endtask
   task automatic rxf(input logic [8:0] d, input logic par, stp, ovr);
      rxFrameData <= d;
      rxFrameParity <= par;
      rxFrameStop <= stp;
      rxOverrun <= ovr;
      rxFrameValid <= 1'b1;
      @(posedge sys_clk);
      rxFrameValid <= 1'b0;
      rxOverrun <= 1'b0;
   endtask
   task automatic waitfor(input int which);
      c = 0;
      do begin
         @(posedge sys_clk);
         c++;
      end while (!(which ? txShiftDone : baudTick) && c < 600);
      lim(c);
   endtask
   task automatic send();
      sendReq <= 1'b1;
      tick(1);
      sendReq <= 1'b0;
   endtask
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rxFrameData, txFrameData} = '0;
      {globalIrqEnable, txDoneIrqTaken, rxFrameValid, rxFrameParity, rxFrameStop} = '0;
      {rxOverrun, rxBufferRead, sendReq} = '0;
      s_axi_wstrb = 4'hF;
      tick(4);
      rst_n <= 1'b1;
      tick(2);
      rdchk(OFF_CTRL_B, CTRL_B_RESET);
      rdchk(OFF_CTRL_C, CTRL_C_RESET);
      rdchk(OFF_CTRL_A, 8'h20);
      `CHK(dataBits, BITS_DEFAULT)
      wr(OFF_CTRL_B, 8'h03);
      rdchk(OFF_CTRL_B, 8'h01);
      `CHK(transmitNinthBit, 1'b1)
      // Reserved mode and parity codes are never written
      for (int m = 0; m < 4; m++) begin
         mo = {m[1], m[1] | m[0]};
         pa = {m[1] | m[0], m[1] & m[0]};
         v = {mo, pa, m[0], 2'h3, m[0]};
         wr(OFF_CTRL_C, v);
         tick(2);
         `CHK(operatingMode, mo)
         `CHK(parityMode, pa)
         `CHK(twoStopBits, m[0])
         `CHK(txChangeOnRising, !m[0])
         `CHK(rxSampleOnRising, m[0])
         rdchk(OFF_CTRL_C, v);
      end
      for (int k = 0; k < 8; k++) begin
         if (k < 4 || k == 7) begin
            wr(OFF_CTRL_B, {5'h0, k[2], 2'h0});
            wr(OFF_CTRL_C, {5'h0, k[1:0], 1'b0});
            tick(2);
            `CHK(dataBits, k < 4 ? BITS_BASE + k[3:0] : BITS_NINE)
         end
      end
      wr(OFF_CTRL_B, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wr(OFF_CTRL_C, pc[p]);
         txFrameData <= pd[p];
         tick(3);
         `CHK(txParityBit, pe[p])
      end
      wr(OFF_BAUD_HIGH, 8'h0A);
      wr(OFF_BAUD_LOW, 8'hBC);
      `CHK(baudDivisor, 12'hABC)
      rdchk(OFF_BAUD_HIGH, 8'h0A);
      wr(OFF_BAUD_HIGH, 8'h00);
      wr(OFF_BAUD_LOW, 8'h03);
      waitfor(0);
      `CHK(c <= 6, 1'b1)
      waitfor(0);
      `CHK(c, 4)
      wr(8'h14, 8'hFF);
      `CHK(resp, RESP_SLVERR)
      rdchk(8'h14, 8'h00, RESP_SLVERR);
      globalIrqEnable <= 1'b1;
      wr(OFF_CTRL_C, 8'h26);
      wr(OFF_CTRL_B, 8'h90);
      tick(2);
      `CHK(rxPinOwned, 1'b1)
      rxf(9'h001, 1'b0, 1'b0, 1'b1);
      tick(3);
      `CHK(rxIrqReq, 1'b1)
      rdchk(OFF_CTRL_A, 8'hBC);
      globalIrqEnable <= 1'b0;
      tick(3);
      `CHK(rxIrqReq, 1'b0)
      rxf(9'h103, 1'b0, 1'b1, 1'b0);
      rdchk(OFF_CTRL_B, 8'h92);
      rxBufferRead <= 1'b1;
      tick(1);
      rxBufferRead <= 1'b0;
      tick(2);
      rdchk(OFF_CTRL_A, 8'hA0);
      f0 = flushes;
      wr(OFF_CTRL_B, 8'h00);
      tick(3);
      rdchk(OFF_CTRL_A, 8'h20);
      `CHK(flushes - f0, 1)
      `CHK(rxPinOwned, 1'b0)
      rxf(9'h005, 1'b0, 1'b1, 1'b0);
      tick(3);
      rdchk(OFF_CTRL_A, 8'h20);
      globalIrqEnable <= 1'b1;
      wr(OFF_CTRL_B, 8'h68);
      tick(2);
      `CHK(txPinOwned, 1'b1)
      `CHK(emptyIrqReq, 1'b1)
      `CHK(txIrqReq, 1'b0)
      send();
      waitfor(1);
      tick(3);
      `CHK(txIrqReq, 1'b1)
      rdchk(OFF_CTRL_A, 8'h60);
      wr(OFF_CTRL_A, 8'h40);
      tick(2);
      `CHK(txIrqReq, 1'b0)
      send();
      wr(OFF_CTRL_B, 8'h40);
      tick(3);
      `CHK(txPinOwned, 1'b1)
      waitfor(1);
      tick(3);
      `CHK(txPinOwned, 1'b0)
      `CHK(txIrqReq, 1'b1)
      txDoneIrqTaken <= 1'b1;
      tick(1);
      txDoneIrqTaken <= 1'b0;
      tick(2);
      rdchk(OFF_CTRL_A, 8'h20);
      finish_test();
   end
endmodule
`default_nettype wire
